// *** logic/bcc_top.sv ***
`timescale 1ns/1ps
`include "bcc_consts.svh"

module bcc_top
  import bcc_pkg::*;
#(
  parameter int CNT_W = 16
) (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // hall position pins
  input  wire logic        phase_u_pos_plus,
  input  wire logic        phase_u_pos_minus,
  input  wire logic        phase_v_pos_plus,
  input  wire logic        phase_v_pos_minus,
  input  wire logic        phase_w_pos_plus,
  input  wire logic        phase_w_pos_minus,
  // control pins, already sliced by the input comparators
  input  wire logic        rotation_dir,
  input  wire logic        rotation_dir_test_level,
  input  wire logic        energize_reset_level,
  input  wire logic        energize_120_level,
  input  wire logic [7:0]  lead_angle_in,
  input  wire logic        overcurrent_sense,
  // gate drive, pulse and interrupt outputs
  output logic             phase_u_upper_out,
  output logic             phase_u_lower_out,
  output logic             phase_v_upper_out,
  output logic             phase_v_lower_out,
  output logic             phase_w_upper_out,
  output logic             phase_w_lower_out,
  output logic             rev_pulse_out,
  output logic             irq
);

  //////////////////////////////////////////////////////////////////////////////
  // functions

  // forward hall sequence 001,011,010,110,100,101; 7 marks an invalid code
  function automatic logic [2:0] hall_sector(input logic [2:0] h);
    case (h)
      3'h1:    hall_sector = 3'h0;
      3'h3:    hall_sector = 3'h1;
      3'h2:    hall_sector = 3'h2;
      3'h6:    hall_sector = 3'h3;
      3'h4:    hall_sector = 3'h4;
      3'h5:    hall_sector = 3'h5;
      default: hall_sector = 3'h7;
    endcase
  endfunction

  function automatic logic [2:0] sector_step(input logic [2:0] s, input logic rev);
    if (rev) begin
      sector_step = (s == 3'h0) ? 3'h5 : 3'(s - 3'h1);
    end else begin
      sector_step = (s == 3'h5) ? 3'h0 : 3'(s + 3'h1);
    end
  endfunction

  // reverse drives the pattern half a turn away
  function automatic bcc_drive_type sector_pattern(input logic [2:0] s, input logic rev);
    logic [2:0] k;
    k = s;
    sector_pattern = '0;
    if (rev && s < 3'h6) begin
      k = (s >= 3'h3) ? 3'(s - 3'h3) : 3'(s + 3'h3);
    end
    case (k)
      3'h0: begin sector_pattern.u_hi = 1'b1; sector_pattern.v_lo = 1'b1; end
      3'h1: begin sector_pattern.u_hi = 1'b1; sector_pattern.w_lo = 1'b1; end
      3'h2: begin sector_pattern.v_hi = 1'b1; sector_pattern.w_lo = 1'b1; end
      3'h3: begin sector_pattern.v_hi = 1'b1; sector_pattern.u_lo = 1'b1; end
      3'h4: begin sector_pattern.w_hi = 1'b1; sector_pattern.u_lo = 1'b1; end
      3'h5: begin sector_pattern.w_hi = 1'b1; sector_pattern.v_lo = 1'b1; end
      default: sector_pattern = '0;
    endcase
  endfunction

  default clocking dflt_cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  localparam int PIN_W = 19;

  bcc_hall_type     hall_pins;
  logic [PIN_W-1:0] pin_meta_ff;
  logic [PIN_W-1:0] pin_s_ff;
  bcc_hall_type     hall_s;
  logic             dir_s;
  logic             sys_rst;
  logic             lvl_rst_s;
  logic             lvl_120_s;
  logic [7:0]       lead_s;
  logic             oc_s;

  assign hall_pins.plus  = {phase_w_pos_plus, phase_v_pos_plus, phase_u_pos_plus};
  assign hall_pins.minus = {phase_w_pos_minus, phase_v_pos_minus, phase_u_pos_minus};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_meta_ff <= '0;
      pin_s_ff    <= '0;
    end else begin
      pin_meta_ff <= {hall_pins, rotation_dir, rotation_dir_test_level,
                      energize_reset_level, energize_120_level, lead_angle_in,
                      overcurrent_sense};
      pin_s_ff    <= pin_meta_ff;
    end
  end

  assign {hall_s, dir_s, sys_rst, lvl_rst_s, lvl_120_s, lead_s, oc_s} = pin_s_ff;

  //////////////////////////////////////////////////////////////////////////////
  // registers over ahb-lite

  logic        fg_triple_ff;
  logic [7:0]  duty_ff;
  logic [7:0]  period_ff;
  logic [2:0]  int_stat_ff;
  logic [2:0]  int_mask_ff;
  logic        wr_pend_ff;
  logic [7:0]  wr_addr_ff;
  logic [31:0] hrdata_ff;
  logic        hreadyout_ff;
  logic        hresp_ff;
  logic [31:0] status_word;
  logic [31:0] rd_word;
  logic [2:0]  events;
  logic        addr_ok;

  assign addr_ok = hsel && hready && htrans[1];

  always_comb begin
    rd_word = 32'h0000_0000;
    case (haddr[7:0])
      `BCC_OFF_CTRL:     rd_word[`BCC_CTRL_FG_TRIPLE] = fg_triple_ff;
      `BCC_OFF_DUTY:     rd_word[7:0] = duty_ff;
      `BCC_OFF_PERIOD:   rd_word[7:0] = period_ff;
      `BCC_OFF_STATUS:   rd_word = status_word;
      `BCC_OFF_INT_STAT: rd_word[2:0] = int_stat_ff;
      `BCC_OFF_INT_MASK: rd_word[2:0] = int_mask_ff;
      default:           rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff   <= 1'b0;
      wr_addr_ff   <= 8'h00;
      hrdata_ff    <= 32'h0000_0000;
      hreadyout_ff <= 1'b1;
      hresp_ff     <= 1'b0;
    end else begin
      wr_pend_ff   <= addr_ok && hwrite;
      wr_addr_ff   <= haddr[7:0];
      hrdata_ff    <= (addr_ok && !hwrite) ? rd_word : 32'h0000_0000;
      hreadyout_ff <= 1'b1;
      hresp_ff     <= 1'b0;
    end
  end

  assign hrdata    = hrdata_ff;
  assign hreadyout = hreadyout_ff;
  assign hresp     = hresp_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fg_triple_ff <= `BCC_RST_FG_TRIPLE;
      duty_ff      <= `BCC_RST_DUTY;
      period_ff    <= `BCC_RST_PERIOD;
      int_mask_ff  <= `BCC_RST_INT_MASK;
    end else if (sys_rst) begin
      fg_triple_ff <= `BCC_RST_FG_TRIPLE;
      duty_ff      <= `BCC_RST_DUTY;
      period_ff    <= `BCC_RST_PERIOD;
      int_mask_ff  <= `BCC_RST_INT_MASK;
    end else if (wr_pend_ff) begin
      case (wr_addr_ff)
        `BCC_OFF_CTRL:     fg_triple_ff <= hwdata[`BCC_CTRL_FG_TRIPLE];
        `BCC_OFF_DUTY:     duty_ff <= hwdata[7:0];
        `BCC_OFF_PERIOD:   period_ff <= hwdata[7:0];
        `BCC_OFF_INT_MASK: int_mask_ff <= hwdata[2:0];
        default:           ;
      endcase
    end
  end

  // write one to clear; a new event in the same cycle wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      int_stat_ff <= 3'h0;
    end else if (wr_pend_ff && wr_addr_ff == `BCC_OFF_INT_STAT) begin
      int_stat_ff <= (int_stat_ff & ~hwdata[2:0]) | events;
    end else begin
      int_stat_ff <= int_stat_ff | events;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // hall decode, lead angle and commutation

  logic [2:0]   hall_ff;
  logic [2:0]   last_hsec_ff;
  logic [2:0]   drv_sec_ff;
  logic [2:0]   prev_sec_ff;
  logic [3:0]   lead_code_ff;
  bcc_mode_type mode_ff;
  logic [2:0]   hsec;
  logic         hall_chg;
  logic         advance;
  logic         half_done;

  assign hsec     = hall_sector(hall_ff);
  assign hall_chg = hsec != last_hsec_ff;

  // a phase is taken only when its pins disagree
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hall_ff <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (hall_s.plus[i] != hall_s.minus[i]) begin
          hall_ff[i] <= hall_s.plus[i];
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lead_code_ff <= 4'h0;
    end else begin
      lead_code_ff <= lead_s[7:4];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_ff <= MODE_OFF;
    end else if (lvl_120_s) begin
      mode_ff <= MODE_120;
    end else if (lvl_rst_s) begin
      mode_ff <= MODE_OFF;
    end else begin
      mode_ff <= MODE_150;
    end
  end

  bcc_lead_sched #(
    .CNT_W (CNT_W)
  ) u_lead (
    .clk       (hclk),
    .rst_n     (hresetn),
    .clr       (sys_rst),
    .hall_edge (hall_chg),
    .lead_code (lead_code_ff),
    .advance   (advance),
    .half_done (half_done)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      last_hsec_ff <= 3'h7;
      drv_sec_ff   <= 3'h7;
      prev_sec_ff  <= 3'h7;
    end else if (sys_rst) begin
      last_hsec_ff <= 3'h7;
      drv_sec_ff   <= 3'h7;
      prev_sec_ff  <= 3'h7;
    end else if (hall_chg) begin
      last_hsec_ff <= hsec;
      prev_sec_ff  <= drv_sec_ff;
      drv_sec_ff   <= hsec;
    end else if (advance && hsec != 3'h7 && drv_sec_ff == hsec) begin
      prev_sec_ff <= drv_sec_ff;
      drv_sec_ff  <= sector_step(drv_sec_ff, dir_s);
    end
  end

  AST_ADV_FWD: assert property (advance && !hall_chg && hsec != 3'h7 && drv_sec_ff == hsec
      && !dir_s && !sys_rst |=> drv_sec_ff == (($past(drv_sec_ff) == 3'h5) ? 3'h0
      : $past(drv_sec_ff) + 3'h1))
    else $error("forward lead step went the wrong way");
  AST_ADV_REV: assert property (advance && !hall_chg && hsec != 3'h7 && drv_sec_ff == hsec
      && dir_s && !sys_rst |=> drv_sec_ff == (($past(drv_sec_ff) == 3'h0) ? 3'h5
      : $past(drv_sec_ff) - 3'h1))
    else $error("reverse lead step went the wrong way");
  AST_LEAD_QUANT: assert property (##1 lead_code_ff == $past(lead_s[7:4]))
    else $error("lead code is not the top four bits of the lead input");

  //////////////////////////////////////////////////////////////////////////////
  // carrier, overcurrent latch and output stage

  logic [7:0]    carrier_ff;
  logic          carrier_wrap;
  logic          oc_ff;
  logic          sys_ev_ff;
  bcc_drive_type drive_ff;
  bcc_drive_type nxt_drive;
  logic          fg_ff;
  logic          irq_ff;

  assign carrier_wrap = carrier_ff >= period_ff;

  // keeps counting while outputs are held off by the reset level
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      carrier_ff <= 8'h00;
    end else if (sys_rst || carrier_wrap) begin
      carrier_ff <= 8'h00;
    end else begin
      carrier_ff <= carrier_ff + 8'h01;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      oc_ff <= 1'b0;
    end else begin
      oc_ff <= oc_s || (oc_ff && !carrier_wrap && !sys_rst);
    end
  end

  always_comb begin
    nxt_drive = sector_pattern(drv_sec_ff, dir_s);
    if (mode_ff == MODE_150 && !half_done) begin
      nxt_drive = nxt_drive | sector_pattern(prev_sec_ff, dir_s);
    end
    case (mode_ff)
      MODE_150: ;
      MODE_120: ;
      MODE_OFF: nxt_drive = '0;
      default:  nxt_drive = '0;
    endcase
    if (sys_rst || hsec == 3'h7) begin
      nxt_drive = '0;
    end
    if (oc_ff || oc_s || carrier_ff >= duty_ff) begin
      nxt_drive.u_hi = 1'b0;
      nxt_drive.v_hi = 1'b0;
      nxt_drive.w_hi = 1'b0;
    end
  end

  assign events[`BCC_INT_OC]     = oc_s && !oc_ff;
  assign events[`BCC_INT_HALL]   = hall_chg && hsec == 3'h7;
  assign events[`BCC_INT_SYSRST] = sys_rst && !sys_ev_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      drive_ff  <= '0;
      fg_ff     <= 1'b0;
      irq_ff    <= 1'b0;
      sys_ev_ff <= 1'b0;
    end else begin
      drive_ff  <= nxt_drive;
      irq_ff    <= |(int_stat_ff & int_mask_ff);
      sys_ev_ff <= sys_rst;
      if (hsec != 3'h7) begin
        fg_ff <= fg_triple_ff ? ^hall_ff : (hsec < 3'h3);
      end
    end
  end

  assign status_word = {14'h0, dir_s, oc_ff, 2'h0, 2'(mode_ff), lead_code_ff,
                        1'b0, drv_sec_ff, 1'b0, hsec};

  assign phase_u_upper_out = drive_ff.u_hi;
  assign phase_u_lower_out = drive_ff.u_lo;
  assign phase_v_upper_out = drive_ff.v_hi;
  assign phase_v_lower_out = drive_ff.v_lo;
  assign phase_w_upper_out = drive_ff.w_hi;
  assign phase_w_lower_out = drive_ff.w_lo;
  assign rev_pulse_out     = fg_ff;
  assign irq               = irq_ff;

  AST_SYSRST_OFF: assert property (sys_rst |=> drive_ff == '0
      && int_stat_ff[`BCC_INT_SYSRST])
    else $error("system reset level left outputs on or no event");
  AST_RESET_LEVEL_OFF: assert property (mode_ff == MODE_OFF |=> drive_ff == '0)
    else $error("outputs not held low in reset level");
  AST_RESET_COUNTS: assert property (mode_ff == MODE_OFF && !sys_rst && !carrier_wrap
      |=> carrier_ff == $past(carrier_ff) + 8'h01)
    else $error("carrier stopped during output-off reset");
  AST_MODE_120: assert property (lvl_120_s |=> mode_ff == MODE_120)
    else $error("120 degree level did not select 120 degree mode");
  AST_MODE_150: assert property (!lvl_120_s && !lvl_rst_s |=> mode_ff == MODE_150)
    else $error("low width pin did not select 150 degree mode");
  AST_OC_UPPER: assert property (oc_ff |=> !drive_ff.u_hi && !drive_ff.v_hi
      && !drive_ff.w_hi)
    else $error("upper outputs on during overcurrent");
  AST_OC_RELEASE: assert property (oc_ff && carrier_wrap && !oc_s |=> !oc_ff)
    else $error("overcurrent not released at carrier boundary");
  AST_OC_HOLD: assert property (oc_ff && !carrier_wrap && !sys_rst |=> oc_ff)
    else $error("overcurrent released before carrier boundary");
  AST_FG_SINGLE: assert property (!fg_triple_ff && hsec != 3'h7
      |=> rev_pulse_out == ($past(hsec) < 3'h3))
    else $error("single pulse output does not follow the half turn");
  AST_IRQ: assert property (##1 irq == |($past(int_stat_ff) & $past(int_mask_ff)))
    else $error("interrupt output disagrees with status and mask");

  COV_OC_TRIP: cover property (oc_s && !oc_ff ##[1:300] !oc_ff);
  COV_LEAD_STEP: cover property (advance && drv_sec_ff == hsec && hsec != 3'h7);
  COV_MODE_SWITCH: cover property (mode_ff == MODE_150 ##[1:50] mode_ff == MODE_120);
  COV_SYSRST: cover property (sys_rst ##1 !sys_rst);

endmodule

// *** logic/bcc_consts.svh ***
`ifndef BCC_CONSTS_SVH
`define BCC_CONSTS_SVH

// register byte offsets
`define BCC_OFF_CTRL      8'h00
`define BCC_OFF_DUTY      8'h04
`define BCC_OFF_PERIOD    8'h08
`define BCC_OFF_STATUS    8'h0c
`define BCC_OFF_INT_STAT  8'h10
`define BCC_OFF_INT_MASK  8'h14

// field positions
`define BCC_CTRL_FG_TRIPLE 0
`define BCC_INT_OC         0
`define BCC_INT_HALL       1
`define BCC_INT_SYSRST     2
`define BCC_ST_HALL_LSB    0
`define BCC_ST_DRV_LSB     4
`define BCC_ST_LEAD_LSB    8
`define BCC_ST_MODE_LSB    12
`define BCC_ST_OC          16
`define BCC_ST_DIR         17

// reset values
`define BCC_RST_FG_TRIPLE  1'b0
`define BCC_RST_DUTY       8'h00
`define BCC_RST_PERIOD     8'hff
`define BCC_RST_INT_MASK   3'h0

// lead angle: 16 codes, 15 steps of 28/15 degree; fraction of a 60 degree sector
// per step is 28/900, approximated as 127/4096
`define BCC_LEAD_MAX_DEG   28
`define BCC_LEAD_NUM       127
`define BCC_LEAD_SHIFT     12

`endif

// *** logic/bcc_pkg.sv ***
package bcc_pkg;

  typedef enum logic [1:0] {
    MODE_150,
    MODE_120,
    MODE_OFF
  } bcc_mode_type;

  typedef struct packed {
    logic u_hi;
    logic u_lo;
    logic v_hi;
    logic v_lo;
    logic w_hi;
    logic w_lo;
  } bcc_drive_type;

  typedef struct packed {
    logic [2:0] plus;
    logic [2:0] minus;
  } bcc_hall_type;

endpackage

// *** logic/bcc_lead_sched.sv ***
`timescale 1ns/1ps
`include "bcc_consts.svh"

// measures the time between hall edges and fires an early step
module bcc_lead_sched #(
  parameter int CNT_W = 16
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             clr,
  // timing
  input  wire logic             hall_edge,
  input  wire logic [3:0]       lead_code,
  output logic                  advance,
  output logic                  half_done
);

  // the product and the age counter are only sized for this span
  if (CNT_W < 8 || CNT_W > 24) begin : g_bad_cnt_w
    $error("bcc_lead_sched: CNT_W out of range");
  end

  localparam int PW = CNT_W + 4 + 7;

  logic [CNT_W-1:0] age_ff;
  logic [CNT_W-1:0] interval_ff;
  logic             fired_ff;
  logic [PW-1:0]    prod;
  logic [CNT_W-1:0] adv_cyc;
  logic             fire;

  assign prod    = PW'(interval_ff) * PW'(lead_code) * PW'(`BCC_LEAD_NUM);
  assign adv_cyc = CNT_W'(prod >> `BCC_LEAD_SHIFT);
  assign fire    = (lead_code != 4'h0) && !fired_ff && (interval_ff != '0)
                   && (age_ff >= interval_ff - adv_cyc);
  assign advance   = fire && !hall_edge;
  assign half_done = age_ff >= (interval_ff >> 1);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      age_ff      <= '0;
      interval_ff <= '0;
      fired_ff    <= 1'b0;
    end else if (clr) begin
      age_ff      <= '0;
      interval_ff <= '0;
      fired_ff    <= 1'b0;
    end else if (hall_edge) begin
      interval_ff <= age_ff;
      age_ff      <= '0;
      fired_ff    <= 1'b0;
    end else begin
      if (age_ff != '1) begin
        age_ff <= age_ff + 1'b1;
      end
      if (fire) begin
        fired_ff <= 1'b1;
      end
    end
  end

endmodule

// *** bench/bcc_hall_model.sv ***
`timescale 1ns/1ps

// turns a sector number into differential hall pins; 6 gives 000, 7 gives 111
module bcc_hall_model (
  // sector request
  input  wire logic [2:0] sector,
  // hall pins
  output logic            phase_u_pos_plus,
  output logic            phase_u_pos_minus,
  output logic            phase_v_pos_plus,
  output logic            phase_v_pos_minus,
  output logic            phase_w_pos_plus,
  output logic            phase_w_pos_minus
);
  // {w,v,u} in forward rotation order
  localparam logic [2:0] SEQ [8] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5, 3'h0, 3'h7};
  logic [2:0] code;

  assign code              = SEQ[sector];
  assign phase_u_pos_plus  = code[0];
  assign phase_u_pos_minus = ~code[0];
  assign phase_v_pos_plus  = code[1];
  assign phase_v_pos_minus = ~code[1];
  assign phase_w_pos_plus  = code[2];
  assign phase_w_pos_minus = ~code[2];
endmodule

// *** bench/bldc_commutation_control_tb.sv ***
`timescale 1ns/1ps
`include "bcc_consts.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin num_errors++; \
  $display("mismatch at %0t: got %h exp %h", $time, g, e); end end

module bldc_commutation_control_tb;
  import bcc_pkg::*;

  localparam logic [5:0] PAT [6]  = '{6'h24, 6'h21, 6'h09, 6'h18, 6'h12, 6'h06};
  localparam logic [2:0] HALL [6] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};

  logic          hclk = 1'b0;
  logic          hresetn = 1'b0;
  logic          hsel = 1'b0;
  logic   [31:0] haddr = 32'h0;
  logic    [1:0] htrans = 2'h0;
  logic          hwrite = 1'b0;
  logic   [31:0] hwdata = 32'h0;
  logic   [31:0] hrdata;
  logic          hreadyout;
  logic          hresp;
  logic    [2:0] sector = 3'h0;
  logic    [5:0] hp;
  logic          dir = 1'b0;
  logic          tst = 1'b0;
  logic          rst_lvl = 1'b0;
  logic          lvl120 = 1'b1;
  logic    [7:0] lead = 8'h00;
  logic          oc = 1'b0;
  bcc_drive_type drv;
  logic          fg;
  logic          irq;
  logic          rd_dph = 1'b0;
  logic   [31:0] rd_q [$];
  logic   [15:0] drv_q [$];
  event          drv_ev;
  int            num_errors = 0;
  int            check_count = 0;

  always #50 hclk = ~hclk;

  bcc_hall_model bcc_hall_model_inst (
    .sector(sector), .phase_u_pos_plus(hp[0]), .phase_u_pos_minus(hp[1]),
    .phase_v_pos_plus(hp[2]), .phase_v_pos_minus(hp[3]),
    .phase_w_pos_plus(hp[4]), .phase_w_pos_minus(hp[5]));

  bcc_top bcc_top_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .phase_u_pos_plus(hp[0]), .phase_u_pos_minus(hp[1]), .phase_v_pos_plus(hp[2]),
    .phase_v_pos_minus(hp[3]), .phase_w_pos_plus(hp[4]), .phase_w_pos_minus(hp[5]),
    .rotation_dir(dir), .rotation_dir_test_level(tst), .energize_reset_level(rst_lvl),
    .energize_120_level(lvl120), .lead_angle_in(lead), .overcurrent_sense(oc),
    .phase_u_upper_out(drv.u_hi), .phase_u_lower_out(drv.u_lo),
    .phase_v_upper_out(drv.v_hi), .phase_v_lower_out(drv.v_lo),
    .phase_w_upper_out(drv.w_hi), .phase_w_lower_out(drv.w_lo),
    .rev_pulse_out(fg), .irq(irq));

  ////////////////////////////////////////////////////////////////////////////
  // monitors: read data phases and drive snapshots
  always @(posedge hclk) begin
    logic [31:0] r;
    if (rd_dph && hreadyout === 1'b1) begin
      r = rd_q.pop_front();
      `CHK({hresp, hrdata}, {1'b0, r})
    end
    if (hreadyout === 1'b1) rd_dph <= hsel && htrans[1] && !hwrite;
  end

  always @(drv_ev) begin
    logic [15:0] n;
    n = drv_q.pop_front();
    `CHK({irq, fg, drv} & n[15:8], n[7:0])
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge hclk);
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask

  task automatic see(input logic [7:0] m, input logic [7:0] e);
    drv_q.push_back({m, e});
    @(negedge hclk);
    -> drv_ev;
    @(posedge hclk);
  endtask

  // twelve hall steps of 40 cycles; r reverse, t triple pulse, w 150 degree overlap
  task automatic run(input logic r, input logic t, input logic w);
    int s;
    int p;
    logic [5:0] e;
    for (int k = 0; k < 12; k++) begin
      s = r ? (12 - k) % 6 : k % 6;
      p = r ? (s + 1) % 6 : (s + 5) % 6;
      e = PAT[r ? (s + 3) % 6 : s];
      if (w) e = e | PAT[r ? (p + 3) % 6 : p];
      sector <= 3'(s);
      tick(6);
      if (k > 1) see(8'hff, {1'b0, t ? ^HALL[s] : 1'(s < 3), e});
      else tick(1);
      tick(33);
    end
  endtask

  task automatic end_of_test();
    if (rd_q.size() != 0 || drv_q.size() != 0) num_errors++;
    if (num_errors == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #2000000;
    num_errors++;
    end_of_test();
  end

  initial begin
    int c;
    int adv;
    int s;
    logic [31:0] d;
    void'($urandom(32'h53c1d669));
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(`BCC_OFF_CTRL, 32'h0);
    rd(`BCC_OFF_DUTY, 32'h0);
    rd(`BCC_OFF_PERIOD, 32'hff);
    rd(`BCC_OFF_INT_MASK, 32'h0);
    bus(1'b1, 8'h20, 32'hffffffff);
    rd(8'h20, 32'h0);
    repeat (4) begin
      d = $urandom;
      bus(1'b1, `BCC_OFF_DUTY, d);
      rd(`BCC_OFF_DUTY, {24'h0, d[7:0]});
    end
    bus(1'b1, `BCC_OFF_PERIOD, 32'h10);
    bus(1'b1, `BCC_OFF_DUTY, 32'hff);
    bus(1'b1, `BCC_OFF_INT_STAT, 32'h7);
    rd(`BCC_OFF_INT_STAT, 32'h0);
    run(1'b0, 1'b0, 1'b0);
    bus(1'b1, `BCC_OFF_CTRL, 32'h1);
    dir <= 1'b1;
    run(1'b1, 1'b1, 1'b0);
    dir <= 1'b0;
    lvl120 <= 1'b0;
    run(1'b0, 1'b1, 1'b1);
    rst_lvl <= 1'b1;
    tick(8);
    see(8'h3f, 8'h00);
    rst_lvl <= 1'b0;
    lvl120 <= 1'b1;
    tick(8);
    see(8'h3f, {2'b00, PAT[5]});
    // overcurrent with the interrupt unmasked, then masked
    bus(1'b1, `BCC_OFF_INT_MASK, 32'h1);
    oc <= 1'b1;
    tick(6);
    see(8'hbf, {2'b10, PAT[5] & 6'h15});
    oc <= 1'b0;
    for (int i = 0; i < 24 && drv !== PAT[5]; i++) @(posedge hclk);
    see(8'hbf, {2'b10, PAT[5]});
    rd(`BCC_OFF_INT_STAT, 32'h1);
    bus(1'b1, `BCC_OFF_INT_STAT, 32'h1);
    tick(2);
    see(8'h80, 8'h00);
    bus(1'b1, `BCC_OFF_INT_MASK, 32'h0);
    oc <= 1'b1;
    tick(6);
    see(8'hbf, {2'b00, PAT[5] & 6'h15});
    oc <= 1'b0;
    rd(`BCC_OFF_INT_STAT, 32'h1);
    for (int i = 6; i < 8; i++) begin
      sector <= 3'(i);
      tick(6);
      see(8'h3f, 8'h00);
    end
    rd(`BCC_OFF_INT_STAT, 32'h3);
    sector <= 3'h5;
    tick(40);
    // lead: random code 8..15 forward, then full code in reverse; steps of 400 cycles
    for (int j = 0; j < 2; j++) begin
      c = j ? 15 : 8 + $urandom % 8;
      lead <= j ? 8'hff : {4'(c), 4'($urandom)};
      dir <= 1'(j);
      adv = (400 * c * 127) >> 12;
      for (int k = 0; k < 9; k++) begin
        s = j ? (12 - k) % 6 : k % 6;
        sector <= 3'(s);
        if (k < 5) tick(400);
        else begin
          tick(409 - adv);
          see(8'h3f, {2'b00, PAT[(s + 1 + j) % 6]});
          tick(adv - 10);
        end
      end
    end
    bus(1'b1, `BCC_OFF_DUTY, 32'h55);
    tst <= 1'b1;
    tick(6);
    tst <= 1'b0;
    tick(6);
    rd(`BCC_OFF_DUTY, 32'h0);
    rd(`BCC_OFF_PERIOD, 32'hff);
    rd(`BCC_OFF_CTRL, 32'h0);
    rd(`BCC_OFF_INT_STAT, 32'h7);
    see(8'h2a, 8'h00);
    end_of_test();
  end
endmodule
